// file: rtl/vif_defines.svh
// constants for the video input bus front end
`ifndef VIF_DEFINES_SVH
`define VIF_DEFINES_SVH

// serial control port slave address byte (write form, read form adds bit 0)
`define VIF_SLAVE_ADDR 8'hE0
// sub-address of the input mode register
`define VIF_SUB_MODE 8'h00
// sub-address of the sample edge register
`define VIF_SUB_EDGE 8'h01
// bit of the mode register that selects the 16-bit input mode
`define VIF_MODE16_BIT 0
// bit of the sample edge register: 0 rising, 1 falling
`define VIF_EDGE_BIT 3
// reset values
`define VIF_MODE_RST 8'h00
`define VIF_EDGE_RST 8'h00
// serial byte length in bits
`define VIF_BYTE_BITS 4'h8

`endif

// file: rtl/vif_pkg.sv
// types shared by the video input bus front end
package vif_pkg;

   // one captured pixel bus word with its syncs
   typedef struct packed {
      logic [15:0] data;
      logic line_sync;
      logic frame_sync;
   } vif_pixel_s;

   // serial control port protocol states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_SUB,
      ST_SUB_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK
   } vif_ser_state_e;

endpackage

// file: rtl/vif_sync2.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none

module vif_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] stage1_ff; // metastable stage, read only by stage2
   logic [WIDTH-1:0] stage2_ff; // settled copy

   // both stages clear to zero, so reset_low reads as reset at start
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= d_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign q_out = stage2_ff;

endmodule

`default_nettype wire

// file: rtl/vif_frontend.sv
// video input bus front end: pixel capture and serial control port slave
// Function
// - capture bus on edge chosen by bit 3
// - syncs used only in 16-bit mode
// - low reset input holds logic in reset
// - serial data pin stays input during reset
// - serial port answers only address E0h
// - data changes on serial clock fall, released on start or stop
`timescale 1ns/1ps
`default_nettype none
`include "vif_defines.svh"

module vif_frontend
   import vif_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic reset_low_in,
   input wire logic pixel_transfer_clock_in,
   input wire logic [15:0] pixel_data_in,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic serial_clock_in,
   input wire logic serial_data_io_in,
   output logic serial_data_io_out,
   output logic serial_data_io_oe_out,
   output vif_pixel_s pixel_out,
   output logic pixel_valid_out,
   output logic wide_mode_out,
   output logic edge_select_out
);

   localparam logic [7:0] SLAVE_ADDR = `VIF_SLAVE_ADDR;
   localparam logic [7:0] EDGE_RST = `VIF_EDGE_RST;
   localparam logic [3:0] BYTE_BITS = `VIF_BYTE_BITS;

   logic [21:0] pins_s; // synchronised pin bundle
   logic pclk_s; // pixel clock level
   logic scl_s; // serial clock level
   logic sda_s; // serial data level
   logic reset_low_s; // device reset pin level
   logic hs_s; // line sync level
   logic vs_s; // frame sync level
   logic [15:0] data_s; // pixel data levels
   logic core_rst; // combined reset, high active

   logic pclk_d_ff; // previous pixel clock level
   logic scl_d_ff; // previous serial clock level
   logic sda_d_ff; // previous serial data level
   logic pclk_rise;
   logic pclk_fall;
   logic capture; // chosen edge seen
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   vif_pixel_s pixel_ff; // captured word
   logic valid_ff; // one-cycle capture pulse
   vif_ser_state_e state_ff; // serial protocol state
   logic [3:0] cnt_ff; // bit count in byte
   logic [7:0] shift_ff; // serial shift register
   logic [7:0] sub_ff; // sub-address pointer
   logic rw_ff; // current transfer is a read
   logic drive_ff; // pulling serial data low
   logic [7:0] mode_reg_ff; // input mode register
   logic [7:0] edge_reg_ff; // sample edge register
   logic wide_q; // 16-bit mode selected
   logic edge_sel; // falling edge selected
   logic wr_stb; // data byte complete, write it
   logic sub_ld; // sub-address byte complete
   logic rd_load; // next read byte goes out
   logic [7:0] rd_val; // byte the pointer currently reads back

   // register read decode, used at address ack and at each master ack
   function automatic logic [7:0] reg_read(input logic [7:0] sub,
                                            input logic [7:0] mode_v,
                                            input logic [7:0] edge_v);
      logic [7:0] val;
      val = 8'h00;
      if (sub == `VIF_SUB_MODE) begin
         val = mode_v;
      end else if (sub == `VIF_SUB_EDGE) begin
         val = edge_v;
      end
      return val;
   endfunction

   // every pin crosses two flip-flops before any logic looks at it
   vif_sync2 #(
      .WIDTH(22)
   ) u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in({pixel_transfer_clock_in, serial_clock_in, serial_data_io_in, reset_low_in,
             line_sync_in, frame_sync_in, pixel_data_in}),
      .q_out(pins_s)
   );

   assign {pclk_s, scl_s, sda_s, reset_low_s, hs_s, vs_s, data_s} = pins_s;

   // pin reset joins the system reset; pin path adds two cycles of lag
   assign core_rst = !rstn_in || !reset_low_s;

   // previous levels for edge detection
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         pclk_d_ff <= 1'b0;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         pclk_d_ff <= pclk_s;
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign pclk_rise = pclk_s && !pclk_d_ff;
   assign pclk_fall = !pclk_s && pclk_d_ff;
   assign capture = edge_sel ? pclk_fall : pclk_rise;
   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   // start and stop are data moving while the clock stays high
   assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
   assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   // read-back value held in a net, so its top bit can be picked without indexing a call
   assign rd_val = reg_read(sub_ff, mode_reg_ff, edge_reg_ff);

   assign wide_q = mode_reg_ff[`VIF_MODE16_BIT];
   assign edge_sel = edge_reg_ff[`VIF_EDGE_BIT];

   // pixel capture; data and clock share the same sync lag, so they stay aligned
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         pixel_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= capture;
         if (capture) begin
            // narrow mode ignores the syncs and the unused upper lanes
            pixel_ff.data <= wide_q ? data_s : {8'h00, data_s[7:0]};
            pixel_ff.line_sync <= wide_q && hs_s;
            pixel_ff.frame_sync <= wide_q && vs_s;
         end
      end
   end

   // strobes shared by the pointer and register processes
   assign wr_stb = (state_ff == ST_WDATA) && scl_fall && (cnt_ff == BYTE_BITS)
                   && !start_det && !stop_det;
   assign sub_ld = (state_ff == ST_SUB) && scl_fall && (cnt_ff == BYTE_BITS)
                   && !start_det && !stop_det;
   assign rd_load = scl_fall && !start_det && !stop_det
                    && (((state_ff == ST_ADDR_ACK) && rw_ff) || (state_ff == ST_RACK));

   // serial protocol; the data pin changes on a clock fall, and is released on start or stop
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         drive_ff <= 1'b0;
      end else if (start_det) begin
         // start or repeated start aborts whatever was going on
         state_ff <= ST_ADDR;
         cnt_ff <= 4'h0;
         drive_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
         drive_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_ADDR, ST_SUB, ST_WDATA: begin
               if (scl_rise && (cnt_ff != BYTE_BITS)) begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                  cnt_ff <= cnt_ff + 4'h1;
               end else if (scl_fall && (cnt_ff == BYTE_BITS)) begin
                  cnt_ff <= 4'h0;
                  if (state_ff == ST_ADDR) begin
                     if (shift_ff[7:1] == SLAVE_ADDR[7:1]) begin
                        drive_ff <= 1'b1;
                        rw_ff <= shift_ff[0];
                        state_ff <= ST_ADDR_ACK;
                     end else begin
                        // not ours: stay silent until the next start
                        state_ff <= ST_IDLE;
                     end
                  end else if (state_ff == ST_SUB) begin
                     drive_ff <= 1'b1;
                     state_ff <= ST_SUB_ACK;
                  end else begin
                     drive_ff <= 1'b1;
                     state_ff <= ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK, ST_RACK: begin
               if (scl_rise && (state_ff == ST_RACK) && sda_s) begin
                  // master said no more: release and wait for stop
                  state_ff <= ST_IDLE;
               end else if (rd_load) begin
                  shift_ff <= rd_val;
                  drive_ff <= !rd_val[7];
                  cnt_ff <= 4'h1;
                  state_ff <= ST_RDATA;
               end else if (scl_fall) begin
                  drive_ff <= 1'b0;
                  state_ff <= ST_SUB;
               end
            end
            ST_SUB_ACK, ST_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_ff <= 1'b0;
                  state_ff <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_ff == BYTE_BITS) begin
                     drive_ff <= 1'b0; // let the master answer
                     state_ff <= ST_RACK;
                  end else begin
                     drive_ff <= !shift_ff[6];
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     cnt_ff <= cnt_ff + 4'h1;
                  end
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // sub-address pointer, advancing after each byte for burst access
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         sub_ff <= 8'h00;
      end else if (sub_ld) begin
         sub_ff <= shift_ff;
      end else if (wr_stb || rd_load) begin
         sub_ff <= sub_ff + 8'h01;
      end
   end

   // control registers; defaults stand until the host writes them
   always_ff @(posedge clk_in) begin
      if (core_rst) begin
         mode_reg_ff <= `VIF_MODE_RST;
         edge_reg_ff <= EDGE_RST;
      end else if (wr_stb) begin
         if (sub_ff == `VIF_SUB_MODE) begin
            mode_reg_ff <= shift_ff;
         end else if (sub_ff == `VIF_SUB_EDGE) begin
            edge_reg_ff <= shift_ff;
         end
      end
   end

   // open drain: only ever pull low, and never while in reset
   assign serial_data_io_out = 1'b0;
   assign serial_data_io_oe_out = drive_ff && !core_rst;
   assign pixel_out = pixel_ff;
   assign pixel_valid_out = valid_ff;
   assign wide_mode_out = wide_q;
   assign edge_select_out = edge_sel;

   // address byte fully shifted in and closing
   sequence s_addr_done;
      (state_ff == ST_ADDR) && scl_fall && (cnt_ff == BYTE_BITS) && !start_det && !stop_det;
   endsequence

   a_reset_no_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !reset_low_s |-> !serial_data_io_oe_out ##1 !drive_ff)
      else $error("serial data driven during reset");

   a_reset_holds_state: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !reset_low_s |=> (state_ff == ST_IDLE) && !pixel_valid_out && (edge_reg_ff == EDGE_RST))
      else $error("logic left reset state while reset pin low");

   a_rise_capture: assert property (@(posedge clk_in) disable iff (core_rst)
      (pclk_rise && !edge_sel) |=> pixel_valid_out && (pixel_out.data[7:0] == $past(data_s[7:0])))
      else $error("rising edge sample missed");

   a_fall_capture: assert property (@(posedge clk_in) disable iff (core_rst)
      (pclk_fall && edge_sel) |=> pixel_valid_out && (pixel_out.data[7:0] == $past(data_s[7:0])))
      else $error("falling edge sample missed");

   a_narrow_no_sync: assert property (@(posedge clk_in) disable iff (core_rst)
      (pixel_valid_out && !$past(wide_q)) |->
         !pixel_out.line_sync && !pixel_out.frame_sync && (pixel_out.data[15:8] == 8'h00))
      else $error("sync used outside 16-bit mode");

   a_addr_ack_own: assert property (@(posedge clk_in) disable iff (core_rst)
      s_addr_done ##0 (shift_ff[7:1] == SLAVE_ADDR[7:1]) |=> drive_ff ##1 (state_ff == ST_ADDR_ACK))
      else $error("own address not acknowledged");

   a_addr_ignore_other: assert property (@(posedge clk_in) disable iff (core_rst)
      s_addr_done ##0 (shift_ff[7:1] != SLAVE_ADDR[7:1]) |=> !drive_ff && (state_ff == ST_IDLE))
      else $error("foreign address answered");

   a_sda_change_low: assert property (@(posedge clk_in) disable iff (core_rst)
      $changed(drive_ff) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
      else $error("serial data moved while clock high");

   a_edge_default_hold: assert property (@(posedge clk_in) disable iff (core_rst)
      !$past(wr_stb) |-> $stable(edge_reg_ff))
      else $error("edge select changed without a host write");

endmodule

`default_nettype wire

// file: bench/vif_host_model.sv
// host side model: pixel source and serial control port master
`timescale 1ns/1ps
`default_nettype none

module vif_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic pclk_out,
   output logic [15:0] data_out,
   output logic hs_out,
   output logic vs_out,
   output logic scl_out,
   output logic sda_low_out
);
   // idle: clock parked low, serial lines released to the pull-up
   initial begin
      pclk_out = 1'b0;
      {data_out, hs_out, vs_out} = 18'h3FFFF;
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // wait whole cycles, always ending just after a falling edge
   task automatic w(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // one pixel clock pulse; word valid only around the chosen edge
   // syncs always driven, so a design that misuses them shows it
   task automatic pix(input logic [15:0] d, input logic hs, input logic vs, input logic fall);
      {data_out, hs_out, vs_out} = fall ? ~{d, hs, vs} : {d, hs, vs};
      w(4);
      pclk_out = 1'b1;
      w(4);
      {data_out, hs_out, vs_out} = fall ? {d, hs, vs} : ~{d, hs, vs};
      w(4);
      pclk_out = 1'b0;
      w(4);
      // hold time over: bus shows a changed pattern, never the old word
      {data_out, hs_out, vs_out} = ~{d, hs, vs};
   endtask

   // start or repeated start: data falls while clock is high
   task automatic start();
      sda_low_out = 1'b0;
      w(4);
      scl_out = 1'b1;
      w(4);
      sda_low_out = 1'b1;
      w(4);
      scl_out = 1'b0;
      w(2);
   endtask

   // stop: data rises while clock is high
   task automatic stop();
      sda_low_out = 1'b1;
      w(4);
      scl_out = 1'b1;
      w(4);
      sda_low_out = 1'b0;
      w(4);
   endtask

   // one bit: data set only while the clock is low
   task automatic sbit(input logic b, output logic s);
      sda_low_out = !b;
      w(4);
      scl_out = 1'b1;
      w(4);
      s = sda_in;
      scl_out = 1'b0;
      w(2);
   endtask

   // byte out msb first, ninth bit released; ack is the sampled level
   task automatic sbyte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sbit(v[i], s);
      end
      sbit(1'b1, ack);
   endtask

   // write one register; adr normally the device address E0h
   task automatic write(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] val,
                        output logic [2:0] acks);
      start();
      sbyte(adr, acks[2]);
      sbyte(sub, acks[1]);
      sbyte(val, acks[0]);
      stop();
   endtask

   // read one register through repeated start and read address
   task automatic read(input logic [7:0] sub, output logic [7:0] v, output logic [2:0] acks);
      logic s;
      start();
      sbyte(8'hE0, acks[2]);
      sbyte(sub, acks[1]);
      start();
      sbyte(8'hE1, acks[0]);
      for (int i = 7; i >= 0; i--) begin
         sbit(1'b1, v[i]);
      end
      sbit(1'b1, s);
      stop();
   endtask
endmodule

`default_nettype wire

// file: bench/vif_frontend_tb.sv
// self-checking testbench for the video input bus front end
`timescale 1ns/1ps
`default_nettype none

module vif_frontend_tb;
   import vif_pkg::*;

   logic clk_in;
   logic rstn_in;
   logic reset_low_in;
   logic pclk;
   logic [15:0] pdata;
   logic hs;
   logic vs;
   logic scl;
   logic host_low;
   logic sda_w; // resolved open-drain wire
   logic sdo;
   logic oe;
   vif_pixel_s pix_w;
   logic pvalid;
   logic wide;
   logic edge_sel;
   logic mon_rst = 1'b0; // set while the reset pin is held low
   logic oe_bad = 1'b0;
   int bad_count = 0;
   int checked = 0;

   // pull-up: low only if someone pulls
   assign sda_w = !(host_low || (oe && !sdo));

   vif_frontend i_vif_frontend (
      .clk_in(clk_in), .rstn_in(rstn_in), .reset_low_in(reset_low_in),
      .pixel_transfer_clock_in(pclk), .pixel_data_in(pdata),
      .line_sync_in(hs), .frame_sync_in(vs), .serial_clock_in(scl),
      .serial_data_io_in(sda_w), .serial_data_io_out(sdo), .serial_data_io_oe_out(oe),
      .pixel_out(pix_w), .pixel_valid_out(pvalid), .wide_mode_out(wide),
      .edge_select_out(edge_sel)
   );

   vif_host_model i_vif_host_model (
      .clk_in(clk_in), .sda_in(sda_w), .pclk_out(pclk), .data_out(pdata),
      .hs_out(hs), .vs_out(vs), .scl_out(scl), .sda_low_out(host_low)
   );

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // the device must never pull the wire while its reset pin is low
   always @(negedge clk_in) begin
      if (mon_rst && oe === 1'b1) begin
         oe_bad <= 1'b1;
      end
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one pixel pulse, expect exactly one capture with the given word
   task automatic pix_check(input logic [15:0] d, input logic h, input logic v, input logic fall,
                            input logic [17:0] exp);
      int n;
      logic [17:0] got;
      n = 0;
      got = '0;
      fork
         i_vif_host_model.pix(d, h, v, fall);
         repeat (24) begin
            @(negedge clk_in);
            if (pvalid === 1'b1) begin
               n++;
               got = pix_w;
            end
         end
      join
      chk(got, exp);
      chk(18'(n), 18'h1);
      if (n == 0) begin
         finish_test();
      end
   endtask

   // outputs right after release of reset
   task automatic t_defaults();
      chk(18'({wide, edge_sel, oe}), 18'h0);
   endtask

   // 8-bit mode: upper byte and syncs ignored, rising edge by default
   task automatic t_narrow();
      pix_check(16'hA55A, 1'b1, 1'b1, 1'b0, {8'h00, 8'h5A, 2'b00});
   endtask

   // switch to 16-bit mode, syncs now carried through
   task automatic t_wide();
      logic [2:0] a;
      i_vif_host_model.write(8'hE0, 8'h00, 8'h01, a);
      chk(18'(a), 18'h0);
      chk(18'(wide), 18'h1);
      pix_check(16'hC3E1, 1'b1, 1'b0, 1'b0, {16'hC3E1, 2'b10});
      pix_check(16'h0F0F, 1'b0, 1'b1, 1'b0, {16'h0F0F, 2'b01});
   endtask

   // falling edge capture, then read the edge register back
   task automatic t_falling();
      logic [2:0] a;
      logic [7:0] v;
      i_vif_host_model.write(8'hE0, 8'h01, 8'h08, a);
      chk(18'(edge_sel), 18'h1);
      pix_check(16'h1234, 1'b0, 1'b1, 1'b1, {16'h1234, 2'b01});
      i_vif_host_model.read(8'h01, v, a);
      chk({7'h0, a, v}, 18'h008);
   endtask

   // another address is ignored: no ack, no register change
   task automatic t_wrong_addr();
      logic [2:0] a;
      i_vif_host_model.write(8'hE2, 8'h01, 8'h00, a);
      chk(18'(a), 18'h7);
      chk(18'(edge_sel), 18'h1);
   endtask

   // reset pin low: state cleared, serial pin stays an input
   task automatic t_reset_pin();
      logic [2:0] a;
      mon_rst = 1'b1;
      reset_low_in = 1'b0;
      repeat (5) @(negedge clk_in);
      chk(18'({wide, edge_sel}), 18'h0);
      i_vif_host_model.write(8'hE0, 8'h01, 8'h08, a);
      chk(18'({a, oe_bad}), 18'hE);
      chk(18'(edge_sel), 18'h0);
      mon_rst = 1'b0;
      reset_low_in = 1'b1;
      repeat (5) @(negedge clk_in);
      chk(18'(edge_sel), 18'h0);
      pix_check(16'h6996, 1'b1, 1'b0, 1'b0, {8'h00, 8'h96, 2'b00});
   endtask

   // main sequence
   initial begin
      rstn_in = 1'b0;
      reset_low_in = 1'b1;
      repeat (6) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (6) @(negedge clk_in);
      t_defaults();
      t_narrow();
      t_wide();
      t_falling();
      t_wrong_addr();
      t_reset_pin();
      finish_test();
   end
endmodule

`default_nettype wire
